// ===== psc_pkg.sv
// Purpose: Shared constants and types for the serial pot command port
// Assumes: Two wiper channels, 16-bit frames, MSB first
// Notes: Command field is bits 5:4, channel select bits 1:0
package psc_pkg;
   localparam int FRAME_BITS = 16;
   localparam int CNT_W = 4;
   localparam int NUM_CHAN = 2;
   localparam int WIPER_W = 8;
   localparam logic [7:0] WIPER_MID = 8'h80;
   localparam logic [15:0] SHIFT_RST = 16'h0000;
   localparam logic [CNT_W-1:0] CNT_RST = 4'h0;
   localparam int CMD_HI_POS = 5;
   localparam int CMD_LO_POS = 4;
   localparam int CHAN1_POS = 1;
   localparam int CHAN0_POS = 0;
   localparam int CMD_BYTE_LSB = 8;
   localparam logic [1:0] CMD_WRITE = 2'h1;
   localparam logic [1:0] CMD_SHUTDOWN = 2'h2;
   localparam logic [2:0] SYNC_RST_HI = 3'h7;
   localparam logic [2:0] SYNC_RST_LO = 3'h0;

   typedef struct packed {
      logic [7:0] cmd;
      logic [7:0] data;
   } psc_frame_t;

   typedef struct packed {
      logic cs_n;
      logic sck;
      logic sdi;
   } psc_link_t;
endpackage

// ===== psc_port.sv
// Purpose: Serial command receiver for a dual digital potentiometer
// Assumes: Link pins sampled by sys_clk_i, SCK well below sys_clk_i / 4
// Notes: Link edges found after three-stage synchronisers
// Behaviour
// - Support write, shutdown and no-operation only
// - Execute command only on select rise
// - Sample input data on rising clock edge
// - Update serial output on falling clock edge
// - Count rising edges, abort unless nonzero multiple sixteen
// - Decode operation from command bits five four
// - Unused command bits are don't care
// - Command field 00 or 11 does nothing
// - Field 01 loads data into selected wipers
// - Field 10 shuts down selected channels
// - Channel select from command bits one zero
// - Select one applies, zero leaves unchanged
// - Wiper code zero sits at terminal B
// - Reset sets all wipers to mid-scale
// - Mid-scale code is 80h
// - Shutdown opens A, keeps wiper value
// - Valid write leaves shutdown if hardware high
// - Executed command clears shift register to zeros
`timescale 1ns/1ps
`default_nettype none
module psc_port (
   input wire logic sys_clk_i,
   input wire logic rst_b_i,
   input wire logic cs_n_i,
   input wire logic sck_i,
   input wire logic sdi_i,
   input wire logic wiper_reset_n_i,
   input wire logic hw_power_down_n_i,
   output logic sdo_o,
   output logic [psc_pkg::WIPER_W-1:0] wiper0_o,
   output logic [psc_pkg::WIPER_W-1:0] wiper1_o,
   output logic [psc_pkg::NUM_CHAN-1:0] shutdown_o,
   output logic [psc_pkg::NUM_CHAN-1:0] a_open_o,
   output logic cmd_done_o,
   output logic cmd_abort_o
);
   logic [2:0] cs_sync;
   logic [2:0] sck_sync;
   logic [2:0] sdi_sync;
   logic [2:0] wrst_sync;
   logic [2:0] pd_sync;
   psc_pkg::psc_link_t link_now;
   psc_pkg::psc_link_t link_prev;
   logic sck_rise;
   logic sck_fall;
   logic cs_rise;
   logic wrst_low;
   logic pd_high;
   psc_pkg::psc_frame_t shift;
   logic [psc_pkg::CNT_W-1:0] edge_cnt;
   logic edge_seen;
   logic frame_ok;
   logic [1:0] cmd_sel;
   logic [psc_pkg::NUM_CHAN-1:0] chan_sel;
   logic [psc_pkg::WIPER_W-1:0] wiper [psc_pkg::NUM_CHAN];
   logic [psc_pkg::NUM_CHAN-1:0] sw_shutdown;
   logic do_write;
   logic do_shutdown;

   // Three-stage synchronisers on every pin
   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         cs_sync <= psc_pkg::SYNC_RST_HI;
         sck_sync <= psc_pkg::SYNC_RST_LO;
         sdi_sync <= psc_pkg::SYNC_RST_LO;
         wrst_sync <= psc_pkg::SYNC_RST_HI;
         pd_sync <= psc_pkg::SYNC_RST_HI;
      end else begin
         cs_sync <= {cs_sync[1:0], cs_n_i};
         sck_sync <= {sck_sync[1:0], sck_i};
         sdi_sync <= {sdi_sync[1:0], sdi_i};
         wrst_sync <= {wrst_sync[1:0], wiper_reset_n_i};
         pd_sync <= {pd_sync[1:0], hw_power_down_n_i};
      end
   end

   // Accepted levels: change only once stages two and three agree
   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         link_now <= '{cs_n: 1'b1, sck: 1'b0, sdi: 1'b0};
         link_prev <= '{cs_n: 1'b1, sck: 1'b0, sdi: 1'b0};
         wrst_low <= 1'b0;
         pd_high <= 1'b1;
      end else begin
         if (cs_sync[2] == cs_sync[1]) begin
            link_now.cs_n <= cs_sync[2];
         end
         if (sck_sync[2] == sck_sync[1]) begin
            link_now.sck <= sck_sync[2];
         end
         if (sdi_sync[2] == sdi_sync[1]) begin
            link_now.sdi <= sdi_sync[2];
         end
         if (wrst_sync[2] == wrst_sync[1]) begin
            wrst_low <= ~wrst_sync[2];
         end
         if (pd_sync[2] == pd_sync[1]) begin
            pd_high <= pd_sync[2];
         end
         link_prev <= link_now;
      end
   end

   assign sck_rise = link_now.sck & ~link_prev.sck & ~link_now.cs_n;
   assign sck_fall = ~link_now.sck & link_prev.sck & ~link_now.cs_n;
   assign cs_rise = link_now.cs_n & ~link_prev.cs_n;

   // Shift register, MSB first, cleared when a command executes
   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         shift <= psc_pkg::SHIFT_RST;
      end else if (cs_rise && frame_ok) begin
         shift <= psc_pkg::SHIFT_RST;
      end else if (sck_rise) begin
         shift <= {shift[14:0], link_now.sdi};
      end
   end

   // Rising edge counter modulo sixteen
   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         edge_cnt <= psc_pkg::CNT_RST;
         edge_seen <= 1'b0;
      end else if (link_now.cs_n) begin
         edge_cnt <= psc_pkg::CNT_RST;
         edge_seen <= 1'b0;
      end else if (sck_rise) begin
         edge_cnt <= edge_cnt + 4'h1;
         edge_seen <= 1'b1;
      end
   end

   assign frame_ok = edge_seen && (edge_cnt == psc_pkg::CNT_RST);

   // Serial output follows shift MSB, moved on falling edge
   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         sdo_o <= 1'b0;
      end else if (cs_rise) begin
         sdo_o <= 1'b0;
      end else if (sck_fall) begin
         sdo_o <= shift[15];
      end
   end

   // Command decode, unused bits ignored
   assign cmd_sel = {shift.cmd[psc_pkg::CMD_HI_POS], shift.cmd[psc_pkg::CMD_LO_POS]};
   assign chan_sel = {shift.cmd[psc_pkg::CHAN1_POS], shift.cmd[psc_pkg::CHAN0_POS]};
   assign do_write = cs_rise && frame_ok && (cmd_sel == psc_pkg::CMD_WRITE);
   assign do_shutdown = cs_rise && frame_ok && (cmd_sel == psc_pkg::CMD_SHUTDOWN);

   // Per-channel wiper and software shutdown state
   generate
      for (genvar ch = 0; ch < psc_pkg::NUM_CHAN; ch++) begin : g_chan
         always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
            if (!rst_b_i) begin
               wiper[ch] <= psc_pkg::WIPER_MID;
            end else if (wrst_low && link_now.cs_n) begin
               wiper[ch] <= psc_pkg::WIPER_MID;
            end else if (do_write && chan_sel[ch]) begin
               wiper[ch] <= shift.data;
            end
         end
         always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
            if (!rst_b_i) begin
               sw_shutdown[ch] <= 1'b0;
            end else if (do_shutdown && chan_sel[ch]) begin
               sw_shutdown[ch] <= 1'b1;
            end else if (do_write && chan_sel[ch] && pd_high) begin
               sw_shutdown[ch] <= 1'b0;
            end
         end
      end
   endgenerate

   // Wiper outputs: code 00h means B terminal
   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         wiper0_o <= psc_pkg::WIPER_MID;
         wiper1_o <= psc_pkg::WIPER_MID;
      end else begin
         wiper0_o <= wiper[0];
         wiper1_o <= wiper[1];
      end
   end

   // Shutdown output: software or hardware, wiper code kept
   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         shutdown_o <= '0;
      end else begin
         shutdown_o <= sw_shutdown | {psc_pkg::NUM_CHAN{~pd_high}};
      end
   end

   // A terminal open while shut down
   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         a_open_o <= '0;
      end else begin
         a_open_o <= sw_shutdown | {psc_pkg::NUM_CHAN{~pd_high}};
      end
   end

   // Frame result strobes
   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         cmd_done_o <= 1'b0;
         cmd_abort_o <= 1'b0;
      end else begin
         cmd_done_o <= cs_rise && frame_ok;
         cmd_abort_o <= cs_rise && !frame_ok;
      end
   end
endmodule // psc_port
`default_nettype wire

// ===== psc_port_monitor.sv
// Purpose: Port assertions for psc_port
// Assumes: Wiper reset pin held high
// Notes: Bound to every psc_port
`timescale 1ns/1ps
`default_nettype none
module psc_port_monitor (
   input wire logic sys_clk_i,
   input wire logic rst_b_i,
   input wire logic [7:0] wiper0_o,
   input wire logic [1:0] shutdown_o,
   input wire logic [1:0] a_open_o,
   input wire logic cmd_done_o,
   input wire logic cmd_abort_o
);
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (!rst_b_i);
   a_done_single: assert property (cmd_done_o |=> !cmd_done_o) else $error("long done");
   a_abort_single: assert property (cmd_abort_o |=> !cmd_abort_o) else $error("long abort");
   a_done_excl: assert property (!(cmd_done_o && cmd_abort_o)) else $error("done abort");
   a_wiper_cause: assert property ($changed(wiper0_o) |-> $past(cmd_done_o))
      else $error("stray wiper");
   a_open_tracks: assert property (a_open_o == shutdown_o) else $error("open differs");
   a_abort_wiper: assert property (cmd_abort_o |=> $stable(wiper0_o) [*2])
      else $error("abort moved wiper");
   a_abort_shut: assert property (cmd_abort_o |=> $stable(shutdown_o) [*2])
      else $error("abort moved shutdown");
   a_reset_mid: assert property ($rose(rst_b_i) |-> wiper0_o == 8'h80)
      else $error("wiper not mid");
   c_done: cover property (cmd_done_o);
   c_abort: cover property (cmd_abort_o);
   c_shut: cover property (shutdown_o == 2'h3);
endmodule // psc_port_monitor
bind psc_port psc_port_monitor u_mon (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i),
   .wiper0_o(wiper0_o), .shutdown_o(shutdown_o), .a_open_o(a_open_o),
   .cmd_done_o(cmd_done_o), .cmd_abort_o(cmd_abort_o));
`default_nettype wire

// ===== psc_host.sv
// Purpose: Serial host model for psc_port
// Assumes: Clock idles low between frames
// Notes: Data line flips after each frame
`timescale 1ns/1ps
`default_nettype none
module psc_host (
   input wire logic clk,
   output var psc_pkg::psc_link_t link
);
   initial link = '{cs_n: 1'b1, sck: 1'b0, sdi: 1'b0};
   task automatic cyc(input int k);
      repeat (k) @(posedge clk);
      #2;
   endtask
   task automatic send(input psc_pkg::psc_frame_t f, input int n);
      link.cs_n = 1'b0;
      for (int i = 0; i <= 2 * n; i++) begin
         if (!i[0]) link.sdi = f[15 - i / 2 & 15];
         link.sck = i[0];
         cyc(4);
      end
      link = '{cs_n: 1'b1, sck: 1'b0, sdi: ~link.sdi};
      cyc(12);
   endtask
endmodule // psc_host
`default_nettype wire

// ===== tb_psc_port.sv
// Purpose: Self-checking bench for psc_port
// Assumes: psc_host drives the serial link
// Notes: Wipers, shutdown and done count compared
`timescale 1ns/1ps
`default_nettype none
module tb_psc_port;
   logic sys_clk = 1'b0, rst_b = 1'b0, pd_n = 1'b1, done, abort, sdo;
   wire logic [19:0] pins;
   logic [31:0] sdo_cap = 32'h0;
   psc_pkg::psc_link_t lk;
   int failures = 0, n_tests = 0, n_done = 0, n_abort = 0, cyc_n = 0;
   wire [31:0] seen = {4'h0, pins, n_done[7:0]};
   psc_host u_host (.clk(sys_clk), .link(lk));
   psc_port u_dut (.sys_clk_i(sys_clk), .rst_b_i(rst_b), .cs_n_i(lk.cs_n), .sck_i(lk.sck),
      .sdi_i(lk.sdi), .wiper_reset_n_i(1'b1), .hw_power_down_n_i(pd_n), .sdo_o(sdo),
      .wiper0_o(pins[11:4]), .wiper1_o(pins[19:12]), .shutdown_o(pins[3:2]),
      .a_open_o(pins[1:0]), .cmd_done_o(done), .cmd_abort_o(abort));
   initial forever #12.5 sys_clk = ~sys_clk;
   // Chain output, taken just before each link clock fall acts
   always @(negedge lk.sck) begin
      if (!lk.cs_n) sdo_cap = {sdo_cap[30:0], sdo};
   end
   always @(posedge sys_clk) begin
      n_done += int'(done === 1'b1);
      n_abort += int'(abort === 1'b1);
      cyc_n++;
      if (cyc_n == 5000) failures++;
      if (cyc_n == 5000) finish_test();
   end
   task automatic finish_test();
      if (failures == 0 && n_tests > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task automatic chk(input string name, input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      failures += int'(got !== exp);
      if (got !== exp) $display("[FAIL] %s exp %h got %h", name, exp, got);
   endtask
   task automatic t_cmds();
      u_host.cyc(5);
      rst_b = 1'b1;
      u_host.cyc(6);
      u_host.send(16'hD100, 16);
      u_host.send(16'h12FF, 16);
      u_host.send(16'h0355, 16);
      u_host.send(16'h3355, 16);
      u_host.send(16'h1301, 15);
      chk("state", seen, 32'h0FF00004);
      chk("aborts", n_abort, 32'h1);
   endtask
   task automatic t_shut();
      u_host.send(16'h2300, 16);
      u_host.send(16'h1240, 16);
      pd_n = 1'b0;
      u_host.cyc(6);
      u_host.send(16'h1133, 16);
      pd_n = 1'b1;
      u_host.cyc(8);
      chk("state", seen, 32'h04033507);
   endtask
   task automatic t_chain();
      u_host.send(16'h8AC3, 32);
      chk("chain out", sdo_cap, 32'h00008AC3);
      chk("sdo idle", {31'h0, sdo}, 32'h0);
      chk("state", seen, 32'h04033508);
   endtask
   initial begin
      t_cmds();
      t_shut();
      t_chain();
      finish_test();
   end
endmodule // tb_psc_port
`default_nettype wire
